// [common/plsc_pkg.sv]
package plsc_pkg;

    // Register byte offsets
    localparam logic [3:0] PLSC_CTRL_OFS   = 4'h0;
    localparam logic [3:0] PLSC_STAT_OFS   = 4'h4;
    localparam logic [3:0] PLSC_IRQ_OFS    = 4'h8;
    localparam logic [3:0] PLSC_MASK_OFS   = 4'hc;

    // Control field positions
    localparam int PLSC_CTRL_PRE_BIT  = 0;
    localparam int PLSC_CTRL_DIV_LSB  = 1;
    localparam int PLSC_CTRL_DBL_BIT  = 3;
    localparam int PLSC_CTRL_EN_BIT   = 4;

    // Control reset: prescale /5, divider mid (/4), double edge off, enabled
    localparam logic [4:0] PLSC_CTRL_RST  = 5'h1a;

    // Three-level divider select codes
    localparam logic [1:0] PLSC_SEL_LOW   = 2'h0;
    localparam logic [1:0] PLSC_SEL_MID   = 2'h1;
    localparam logic [1:0] PLSC_SEL_HIGH  = 2'h2;

    // Interrupt bit positions
    localparam int PLSC_IRQ_LOCK_BIT  = 0;
    localparam int PLSC_IRQ_UNLK_BIT  = 1;
    localparam int PLSC_IRQ_W         = 2;

    localparam logic [31:0] PLSC_BAD_ADDR_DATA = 32'hdeadbeef;

    // Detector output levels
    typedef enum logic [1:0] {
        PLSC_OUT_MID,
        PLSC_OUT_HIGH,
        PLSC_OUT_LOW
    } plsc_lvl_e;

endpackage

// [verilog/plsc_core.sv]
// Overview of operation
// - Reference comes from oscillator via divider chain
// - Prescale select: high divides 4, low 5
// - Divider select: high 8, low 2, mid 4
// - Feedback input squared to clean logic level
// - Detector compares reference with feedback
// - Equal frequency: active share tracks phase error
// - Any frequency difference gives full drive
// - Lock output flags zero frequency error
// - Double edge doubles effective feedback frequency
// - Double-edge select low enables, high disables
// - Feedback faster holds high, reference faster low
// - Feedback leads: high between edges, else mid
// - Lock line high only in four normal states
// - Double edge uses both feedback edges
//
// The register offsets and the Avalon-MM register port were left to the implementer.
`timescale 1ns/10ps
module plsc_core
    import plsc_pkg::*;
#(
    parameter int FILT_LEN = 3
) (
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    input  wire logic        osc_i,
    input  wire logic        fb_i,
    input  wire logic [3:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    output logic             det_high_o,
    output logic             det_oe_n_o,
    output logic             lock_off_o,
    output logic             ref_o,
    output logic             irq_o
);

    // Detector states 1..10; normal ones are S1,S2,S6,S7
    typedef enum logic [3:0] {
        PLSC_S1, PLSC_S2, PLSC_S3, PLSC_S4, PLSC_S5,
        PLSC_S6, PLSC_S7, PLSC_S8, PLSC_S9, PLSC_S10
    } plsc_state_e;

    function automatic logic [3:0] sel_ratio(input logic [1:0] sel);
        case (sel)
            PLSC_SEL_HIGH: sel_ratio = 4'd8;
            PLSC_SEL_LOW:  sel_ratio = 4'd2;
            default:       sel_ratio = 4'd4;
        endcase
    endfunction

    function automatic logic is_normal(input plsc_state_e s);
        is_normal = (s == PLSC_S1) || (s == PLSC_S2) || (s == PLSC_S6) || (s == PLSC_S7);
    endfunction

    logic [4:0]            ctrl;
    logic [PLSC_IRQ_W-1:0] irq_stat;
    logic [PLSC_IRQ_W-1:0] irq_mask;
    logic                  ack;
    logic                  osc_q;
    logic                  osc_rise;
    logic [2:0]            pre_cnt;
    logic                  pre_tick;
    logic [2:0]            div_cnt;
    logic                  ref_q;
    logic                  ref_rise;
    logic [FILT_LEN-1:0]   fb_sh;
    logic                  fb_sq;
    logic                  fb_sq_q;
    logic                  fb_edge;
    plsc_state_e           state;
    plsc_state_e           next_state;
    plsc_lvl_e             lvl;
    logic                  lock_q;
    logic [PLSC_IRQ_W-1:0] ev;
    logic [2:0]            pre_ratio;
    logic [2:0]            div_half;

    wire logic en     = ctrl[PLSC_CTRL_EN_BIT];
    wire logic dbl_en = ~ctrl[PLSC_CTRL_DBL_BIT];
    wire logic is_wr  = avs_write_i && ack;
    wire logic is_rd  = avs_read_i && !ack;

    // Register bus: one wait cycle, answered on the second edge
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            ack <= 1'b0;
        end else begin
            ack <= (avs_read_i || avs_write_i) && !ack;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            avs_waitrequest_o <= 1'b1;
        end else begin
            avs_waitrequest_o <= !((avs_read_i || avs_write_i) && !ack);
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            ctrl <= PLSC_CTRL_RST;
        end else if (is_wr && avs_address_i == PLSC_CTRL_OFS && avs_byteenable_i[0]) begin
            ctrl <= avs_writedata_i[4:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            irq_mask <= '0;
        end else if (is_wr && avs_address_i == PLSC_MASK_OFS && avs_byteenable_i[0]) begin
            irq_mask <= avs_writedata_i[PLSC_IRQ_W-1:0];
        end
    end

    // Sticky status, write one to clear; a new event wins over the clear
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            irq_stat <= '0;
        end else if (is_wr && avs_address_i == PLSC_IRQ_OFS && avs_byteenable_i[0]) begin
            irq_stat <= (irq_stat & ~avs_writedata_i[PLSC_IRQ_W-1:0]) | ev;
        end else begin
            irq_stat <= irq_stat | ev;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            avs_readdata_o <= '0;
        end else if (is_rd) begin
            case (avs_address_i)
                PLSC_CTRL_OFS: avs_readdata_o <= {27'h0, ctrl};
                PLSC_STAT_OFS: avs_readdata_o <= {24'h0, 4'(state), lvl, ref_q, lock_q};
                PLSC_IRQ_OFS:  avs_readdata_o <= {30'h0, irq_stat};
                PLSC_MASK_OFS: avs_readdata_o <= {30'h0, irq_mask};
                default:       avs_readdata_o <= PLSC_BAD_ADDR_DATA;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(irq_stat & irq_mask);
        end
    end

    // Oscillator rising edge detect
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            osc_q <= 1'b0;
        end else begin
            osc_q <= osc_i;
        end
    end
    assign osc_rise = osc_i && !osc_q;

    assign pre_ratio = ctrl[PLSC_CTRL_PRE_BIT] ? 3'd4 : 3'd5;
    assign div_half  = 3'(sel_ratio(ctrl[PLSC_CTRL_DIV_LSB +: 2]) >> 1);

    // Prescaler stage
    always_ff @(posedge clk_i) begin
        if (!rstn_i || !en) begin
            pre_cnt <= '0;
        end else if (pre_cnt >= pre_ratio) begin
            pre_cnt <= '0;
        end else if (osc_rise) begin
            pre_cnt <= (pre_cnt >= pre_ratio - 3'd1) ? 3'd0 : pre_cnt + 3'd1;
        end
    end
    assign pre_tick = osc_rise && (pre_cnt >= pre_ratio - 3'd1);

    // Second stage toggles the reference every half ratio
    always_ff @(posedge clk_i) begin
        if (!rstn_i || !en) begin
            div_cnt <= '0;
            ref_q   <= 1'b0;
        end else if (div_cnt >= div_half) begin
            div_cnt <= '0;
        end else if (pre_tick) begin
            if (div_cnt >= div_half - 3'd1) begin
                div_cnt <= '0;
                ref_q   <= ~ref_q;
            end else begin
                div_cnt <= div_cnt + 3'd1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            ref_o <= 1'b0;
        end else begin
            ref_o <= ref_q;
        end
    end
    assign ref_rise = pre_tick && (div_cnt >= div_half - 3'd1) && !ref_q;

    // Squaring: level changes only after FILT_LEN equal samples
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            fb_sh <= '0;
            fb_sq <= 1'b0;
        end else begin
            fb_sh <= {fb_sh[FILT_LEN-2:0], fb_i};
            if (&fb_sh) begin
                fb_sq <= 1'b1;
            end else if (~|fb_sh) begin
                fb_sq <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            fb_sq_q <= 1'b0;
        end else begin
            fb_sq_q <= fb_sq;
        end
    end
    // Rising edges only, or both edges with the double-edge option
    assign fb_edge = en && (dbl_en ? (fb_sq ^ fb_sq_q) : (fb_sq && !fb_sq_q));

    // Detector ring: feedback edge moves up, reference edge moves down
    always_comb begin
        next_state = state;
        if (fb_edge && !ref_rise) begin
            case (state)
                PLSC_S1:  next_state = PLSC_S2;
                PLSC_S2:  next_state = PLSC_S5;
                PLSC_S3:  next_state = PLSC_S2;
                PLSC_S4:  next_state = PLSC_S1;
                PLSC_S5:  next_state = PLSC_S6;
                PLSC_S6:  next_state = PLSC_S7;
                PLSC_S7:  next_state = PLSC_S8;
                PLSC_S8:  next_state = PLSC_S9;
                PLSC_S9:  next_state = PLSC_S8;
                PLSC_S10: next_state = PLSC_S1;
                default:  next_state = PLSC_S5;
            endcase
        end else if (ref_rise && !fb_edge) begin
            case (state)
                PLSC_S7:  next_state = PLSC_S6;
                PLSC_S6:  next_state = PLSC_S10;
                PLSC_S10: next_state = PLSC_S2;
                PLSC_S2:  next_state = PLSC_S1;
                PLSC_S1:  next_state = PLSC_S3;
                PLSC_S3:  next_state = PLSC_S4;
                PLSC_S4:  next_state = PLSC_S3;
                PLSC_S9:  next_state = PLSC_S7;
                PLSC_S8:  next_state = PLSC_S6;
                PLSC_S5:  next_state = PLSC_S2;
                default:  next_state = PLSC_S5;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i || !en) begin
            state <= PLSC_S1;
        end else begin
            state <= next_state;
        end
    end

    // Output level: high above S6, low below S2, mid between edges
    always_comb begin
        case (next_state)
            PLSC_S7, PLSC_S8, PLSC_S9: lvl = PLSC_OUT_HIGH;
            PLSC_S3, PLSC_S4:          lvl = PLSC_OUT_LOW;
            PLSC_S1:                   lvl = PLSC_OUT_LOW;
            default:                   lvl = PLSC_OUT_MID;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            det_high_o <= 1'b0;
            det_oe_n_o <= 1'b1;
        end else begin
            det_high_o <= (lvl == PLSC_OUT_HIGH);
            det_oe_n_o <= (lvl == PLSC_OUT_MID);
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            lock_q     <= 1'b1;
            lock_off_o <= 1'b1;
        end else begin
            lock_q     <= is_normal(next_state);
            lock_off_o <= is_normal(next_state);
        end
    end

    assign ev[PLSC_IRQ_LOCK_BIT] = is_normal(next_state) && !lock_q;
    assign ev[PLSC_IRQ_UNLK_BIT] = !is_normal(next_state) && lock_q;

    AST_LOCK_MATCH: assert property (@(posedge clk_i) disable iff (!rstn_i)
        lock_off_o == lock_q) else $error("lock pin and status differ");
    AST_FREQ_HIGH: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (state == PLSC_S8 || state == PLSC_S9) |-> det_high_o && !det_oe_n_o)
        else $error("feedback fast but not full high");
    AST_FREQ_LOW: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (state == PLSC_S3 || state == PLSC_S4) |-> !det_high_o && !det_oe_n_o)
        else $error("reference fast but not full low");
    AST_LOCK_NORMAL: assert property (@(posedge clk_i) disable iff (!rstn_i)
        lock_q |-> is_normal(state)) else $error("lock outside normal state");
    AST_PRE_RANGE: assert property (@(posedge clk_i) disable iff (!rstn_i)
        pre_cnt < pre_ratio || $changed(pre_ratio)) else $error("prescaler overrun");
    AST_DIV_RANGE: assert property (@(posedge clk_i) disable iff (!rstn_i)
        div_cnt < div_half || $changed(div_half)) else $error("divider overrun");
    AST_SQ_STABLE: assert property (@(posedge clk_i) disable iff (!rstn_i)
        $rose(fb_sq) |-> $past(fb_i, 2)) else $error("feedback not squared");
    AST_DBL_FALL: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (en && dbl_en && $fell(fb_sq)) |-> fb_edge)
        else $error("falling edge missed in double mode");
    AST_SGL_FALL: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (!dbl_en && $fell(fb_sq)) |-> !fb_edge)
        else $error("falling edge counted in single mode");

    COV_LOCK: cover property (@(posedge clk_i) disable iff (!rstn_i) $rose(lock_q));
    COV_HIGH: cover property (@(posedge clk_i) disable iff (!rstn_i) state == PLSC_S9);
    COV_LOW:  cover property (@(posedge clk_i) disable iff (!rstn_i) state == PLSC_S4);
    COV_IRQ:  cover property (@(posedge clk_i) disable iff (!rstn_i) $rose(irq_o));

endmodule

// [dv/plsc_sensor_model.sv]
`timescale 1ns/10ps
module plsc_sensor_model #(
    parameter int OSC_HALF = 2
) (
    input  wire logic clk_i,
    input  wire logic [31:0] fb_half_i,
    output logic             osc_o,
    output logic             fb_o
);
    int osc_cnt;
    int fb_cnt;

    initial begin
        osc_o   = 1'b0;
        fb_o    = 1'b0;
        osc_cnt = 0;
        fb_cnt  = 0;
    end

    // Free-running oscillator, well below half the system clock
    always @(posedge clk_i) begin
        if (osc_cnt == OSC_HALF - 1) begin
            osc_cnt <= 0;
            osc_o   <= ~osc_o;
        end else begin
            osc_cnt <= osc_cnt + 1;
        end
    end

    // Speed sensor: square wave, stands still while the motor is stopped
    always @(posedge clk_i) begin
        if (fb_half_i == 0) begin
            fb_cnt <= 0;
        end else if (fb_cnt >= fb_half_i - 1) begin
            fb_cnt <= 0;
            fb_o   <= ~fb_o;
        end else begin
            fb_cnt <= fb_cnt + 1;
        end
    end
endmodule

// [dv/phase_locked_speed_controller_tb_top.sv]
`timescale 1ns/10ps
module phase_locked_speed_controller_tb_top
    import plsc_pkg::*;
;
    logic        clk_i;
    logic        rstn_i;
    logic        osc;
    logic        fb;
    int          fb_half;
    logic [3:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata_o;
    logic        avs_waitrequest_o;
    logic        det_high_o;
    logic        det_oe_n_o;
    logic        lock_off_o;
    logic        ref_o;
    logic        irq_o;
    logic [31:0] q;
    int          errors;
    int          cmp_count;
    int          cyc;
    int          c;
    int          hi;
    int          lo;
    int          mid;
    int          lk;

    plsc_core #(.FILT_LEN(3)) dut (
        .clk_i(clk_i), .rstn_i(rstn_i), .osc_i(osc), .fb_i(fb),
        .avs_address_i(avs_address), .avs_read_i(avs_read), .avs_write_i(avs_write),
        .avs_writedata_i(avs_writedata), .avs_byteenable_i(4'hf),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .det_high_o(det_high_o), .det_oe_n_o(det_oe_n_o), .lock_off_o(lock_off_o),
        .ref_o(ref_o), .irq_o(irq_o)
    );

    plsc_sensor_model #(.OSC_HALF(2)) sensor (
        .clk_i(clk_i), .fb_half_i(fb_half), .osc_o(osc), .fb_o(fb)
    );

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    task finish_test;
        $display("checks %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            errors++;
            finish_test();
        end
    end

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        avs_address   <= a;
        avs_write     <= w;
        avs_read      <= ~w;
        avs_writedata <= d;
        do begin
            @(posedge clk_i);
        end while (avs_waitrequest_o !== 1'b0);
        chk("bus_answer", 1'b0, avs_waitrequest_o);
        q = avs_readdata_o;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk_i);
    endtask

    task rd(input string nm, input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(nm, e, q);
    endtask

    // Cycles between two rising edges of the reference, skipping the first two full periods
    task gap;
        logic p;
        repeat (2) begin
            c = 0;
            p = ref_o;
            for (int k = 0; k < 1000; k++) begin
                @(posedge clk_i);
                if (ref_o === 1'b1 && p === 1'b0 && c > 0) break;
                if (ref_o === 1'b1 && p === 1'b0) c = 1;
                else if (c > 0) c++;
                p = ref_o;
            end
        end
    endtask

    task watch;
        hi = 0;
        lo = 0;
        mid = 0;
        lk = 0;
        repeat (256) begin
            @(posedge clk_i);
            if (det_oe_n_o === 1'b1) mid++;
            else if (det_high_o === 1'b1) hi++;
            else lo++;
            if (lock_off_o === 1'b1) lk++;
        end
    endtask

    initial begin
        errors = 0;
        cmp_count = 0;
        cyc = 0;
        fb_half = 0;
        rstn_i = 1'b0;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        repeat (4) @(posedge clk_i);
        chk("wait_in_reset", 1'b1, avs_waitrequest_o);
        chk("irq_in_reset", 1'b0, irq_o);
        rstn_i <= 1'b1;
        rd("ctrl_reset", PLSC_CTRL_OFS, {27'h0, PLSC_CTRL_RST});
        rd("mask_reset", PLSC_MASK_OFS, 32'h0);
        rd("unmapped", 4'h6, PLSC_BAD_ADDR_DATA);
        bus(1'b1, 4'h6, 32'h0);
        rd("ctrl_kept", PLSC_CTRL_OFS, {27'h0, PLSC_CTRL_RST});
        $display("test registers done");
        for (int p = 0; p < 2; p++) begin
            for (int s = 0; s < 4; s++) begin
                bus(1'b1, PLSC_CTRL_OFS, 32'h18 | (s << 1) | p);
                gap();
                chk("ref_period", (p ? 4 : 5) * (s == 0 ? 2 : s == 2 ? 8 : 4) * 4, c);
            end
        end
        $display("test dividers done");
        bus(1'b1, PLSC_CTRL_OFS, 32'h19);
        fb_half <= 4;
        repeat (200) @(posedge clk_i);
        watch();
        chk("fast_drive_high", 1'b1, hi * 4 >= 768);
        chk("fast_unlocked", 1'b1, lk < 256);
        fb_half <= 64;
        repeat (400) @(posedge clk_i);
        watch();
        chk("slow_drive_low", 1'b1, lo * 4 >= 768);
        $display("test steering done");
        fb_half <= 16;
        repeat (400) @(posedge clk_i);
        watch();
        chk("equal_locked", 256, lk);
        chk("equal_mid_share", 1'b1, mid > 0 && mid < 256);
        chk("equal_one_side", 1'b1, hi == 0 || lo == 0);
        rd("irq_status", PLSC_IRQ_OFS, 32'h3);
        chk("irq_masked", 1'b0, irq_o);
        bus(1'b1, PLSC_MASK_OFS, 32'h1);
        repeat (2) @(posedge clk_i);
        chk("irq_raised", 1'b1, irq_o);
        bus(1'b1, PLSC_IRQ_OFS, 32'h3);
        repeat (2) @(posedge clk_i);
        chk("irq_cleared", 1'b0, irq_o);
        rd("irq_status_clr", PLSC_IRQ_OFS, 32'h0);
        $display("test lock done");
        fb_half <= 32;
        repeat (400) @(posedge clk_i);
        watch();
        chk("single_edge_low", 1'b1, lo * 4 >= 768);
        bus(1'b1, PLSC_CTRL_OFS, 32'h11);
        repeat (400) @(posedge clk_i);
        watch();
        chk("double_edge_lock", 256, lk);
        $display("test double edge done");
        finish_test();
    end
endmodule
